/* isbh_pkg.sv */
// Constants, register map and state encoding of the I2C slave byte handshake block
package isbh_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_SCR = 8'hd7;
    localparam logic [7:0] ADDR_DATA = 8'hd8;
    localparam logic [7:0] ADDR_CFG = 8'hd9;
    localparam logic [7:0] ADDR_OWN = 8'hda;
    // Status/control field positions
    localparam int B_BUS_ERR = 7;
    localparam int B_STOP = 5;
    localparam int B_ACK = 4;
    localparam int B_ADDR = 3;
    localparam int B_XMIT = 2;
    localparam int B_LRB = 1;
    localparam int B_BYTE = 0;
    // Configuration field positions
    localparam int C_HW_MATCH = 0;
    localparam int C_BUF_MODE = 1;
    // Reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [1:0] RST_CFG = 2'h0;
    localparam logic [6:0] RST_OWN = 7'h00;
    // Bit counter landmarks within one nine-clock byte
    localparam logic [3:0] CNT_LAST = 4'h7;
    localparam logic [3:0] CNT_DATA = 4'h8;
    localparam logic [3:0] CNT_ACK = 4'h9;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_RX = 2'b10,
        ST_TX = 2'b11
    } isbh_state_t;
endpackage : isbh_pkg

/* isbh_slave.sv */
// I2C slave byte handshake: status/control, shifter, stall and bus sampling
`timescale 1ns/1ps
module isbh_slave #(
    parameter int BUF_DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic irq_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o
);
    isbh_pkg::isbh_state_t state_reg, state_next;
    logic [1:0] scl_sync_reg, sda_sync_reg;
    logic scl_d_reg, sda_d_reg;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] shift_reg;
    logic [8:0] byte_cnt_reg;
    logic [1:0] cfg_reg;
    logic [6:0] own_reg;
    logic bus_err_reg, stop_reg, ack_ctl_reg, addr_reg, xmit_reg, lrb_reg, bc_reg;
    logic pend_reg, stall_reg, rw_reg, tx_nack_reg;
    logic use_auto_reg, auto_val_reg, ack_sent_reg, addressed_reg, addr_nack_reg;
    logic sda_drv_reg, sda_drv_next;
    logic [7:0] rdata_reg;
    logic irq_reg, scl_oe_n_reg, sda_oe_n_reg;

    // Only the second stage is read; the third gives the edge history
    wire scl_s = scl_sync_reg[1];
    wire sda_s = sda_sync_reg[1];
    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    wire wr_scr = reg_wr_i && (reg_addr_i == isbh_pkg::ADDR_SCR);
    wire wr_data = reg_wr_i && (reg_addr_i == isbh_pkg::ADDR_DATA);
    wire wr_cfg = reg_wr_i && (reg_addr_i == isbh_pkg::ADDR_CFG);
    wire wr_own = reg_wr_i && (reg_addr_i == isbh_pkg::ADDR_OWN);
    wire hw_match_enable = cfg_reg[isbh_pkg::C_HW_MATCH];
    wire buf_mode = cfg_reg[isbh_pkg::C_BUF_MODE];

    wire keep_err = ~wr_scr | reg_wdata_i[isbh_pkg::B_BUS_ERR];
    wire keep_stop = ~wr_scr | reg_wdata_i[isbh_pkg::B_STOP];
    wire keep_addr = ~wr_scr | reg_wdata_i[isbh_pkg::B_ADDR];
    wire keep_lrb = ~wr_scr | reg_wdata_i[isbh_pkg::B_LRB];
    wire keep_bc = ~wr_scr | reg_wdata_i[isbh_pkg::B_BYTE];

    // A write in the cycle of the edge counts as on time
    wire ack_eff = wr_scr ? reg_wdata_i[isbh_pkg::B_ACK] : ack_ctl_reg;
    wire xmit_eff = wr_scr ? reg_wdata_i[isbh_pkg::B_XMIT] : xmit_reg;
    // Pending falling edge proceeds only once firmware has answered
    wire fall_go = (scl_fall & (~pend_reg | wr_scr)) | (stall_reg & wr_scr);

    wire busy = (state_reg != isbh_pkg::ST_IDLE);
    wire last_bit = scl_rise && busy && (cnt_reg == isbh_pkg::CNT_LAST);
    wire addr_byte = last_bit && (state_reg == isbh_pkg::ST_ADDR);
    wire rx_byte = last_bit && (state_reg == isbh_pkg::ST_RX);
    wire tx_ack = scl_rise && (state_reg == isbh_pkg::ST_TX) && (cnt_reg == isbh_pkg::CNT_DATA);
    wire addr_hit = (shift_reg[6:0] == own_reg);
    // Mismatch under hardware matching takes no address
    wire addr_take = addr_byte && (~hw_match_enable | addr_hit);
    // Count of data bytes against the buffer end
    wire beyond = buf_mode && (byte_cnt_reg >= 9'(BUF_DEPTH));
    // Buffer mode with matching flags the address only
    wire data_ev_ok = (~buf_mode | ~hw_match_enable) & ~beyond;
    // Byte event at the sampling rise
    wire bc_set = addr_take | ((rx_byte | tx_ack) & data_ev_ok);
    // Data direction from control bit or address in buffer mode
    wire dir_tx = buf_mode ? rw_reg : xmit_eff;
    wire ack_now = use_auto_reg ? auto_val_reg : ack_eff;
    // Start and stop legal only idle or at a byte boundary outside transmit
    wire edge_ok = ~busy || ((state_reg != isbh_pkg::ST_TX) && (cnt_reg == 4'h0));
    wire ack_slot = fall_go && busy && (cnt_reg == isbh_pkg::CNT_DATA);
    wire addr_slot = ack_slot && (state_reg == isbh_pkg::ST_ADDR);

    wire [7:0] scr_val = {bus_err_reg, 1'b0, stop_reg, ack_ctl_reg,
                          addr_reg, xmit_reg, lrb_reg, bc_reg};
    wire [7:0] rd_mux = (reg_addr_i == isbh_pkg::ADDR_SCR) ? scr_val :
                        (reg_addr_i == isbh_pkg::ADDR_DATA) ? shift_reg :
                        (reg_addr_i == isbh_pkg::ADDR_CFG) ? {6'h00, cfg_reg} :
                        (reg_addr_i == isbh_pkg::ADDR_OWN) ? {1'b0, own_reg} : 8'h00;

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        sda_drv_next = sda_drv_reg;
        if (start_det) begin
            state_next = isbh_pkg::ST_ADDR;
            cnt_next = 4'h0;
            sda_drv_next = 1'b0;
        end else if (stop_det) begin
            state_next = isbh_pkg::ST_IDLE;
            cnt_next = 4'h0;
            sda_drv_next = 1'b0;
        end else if (busy) begin
            if (scl_rise && (cnt_reg != isbh_pkg::CNT_ACK)) begin
                cnt_next = cnt_reg + 4'h1;
            end
            if (fall_go) begin
                if (cnt_reg == isbh_pkg::CNT_DATA) begin
                    // Ack slot driven from ack choice
                    sda_drv_next = (state_reg != isbh_pkg::ST_TX) && ack_now;
                end else if (cnt_reg == isbh_pkg::CNT_ACK) begin
                    cnt_next = 4'h0;
                    sda_drv_next = 1'b0;
                    if (state_reg == isbh_pkg::ST_TX && tx_nack_reg) begin
                        // Transmit after peer NACK idles
                        state_next = isbh_pkg::ST_IDLE;
                    end else if (state_reg != isbh_pkg::ST_TX && !ack_sent_reg) begin
                        // After NACK ignore bus until next start
                        state_next = isbh_pkg::ST_IDLE;
                    end else if (dir_tx) begin
                        state_next = isbh_pkg::ST_TX;
                        sda_drv_next = ~shift_reg[7];
                    end else begin
                        state_next = isbh_pkg::ST_RX;
                    end
                end else if (state_reg == isbh_pkg::ST_TX) begin
                    sda_drv_next = ~shift_reg[7];
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], scl_i};
            sda_sync_reg <= {sda_sync_reg[0], sda_i};
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= isbh_pkg::ST_IDLE;
            cnt_reg <= 4'h0;
            sda_drv_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            sda_drv_reg <= sda_drv_next;
        end
    end

    // Firmware reads and writes the live shifter
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_reg <= isbh_pkg::RST_DATA;
        end else if (wr_data) begin
            shift_reg <= reg_wdata_i;
        end else if (scl_rise && busy && (cnt_reg < isbh_pkg::CNT_DATA)) begin
            shift_reg <= {shift_reg[6:0], sda_s};
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_reg <= isbh_pkg::RST_CFG;
            own_reg <= isbh_pkg::RST_OWN;
        end else begin
            cfg_reg <= wr_cfg ? reg_wdata_i[1:0] : cfg_reg;
            own_reg <= wr_own ? reg_wdata_i[6:0] : own_reg;
        end
    end

    // Byte bookkeeping of the current transaction
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            byte_cnt_reg <= 9'h000;
            rw_reg <= 1'b0;
            tx_nack_reg <= 1'b0;
            use_auto_reg <= 1'b0;
            auto_val_reg <= 1'b0;
            ack_sent_reg <= 1'b0;
        end else begin
            if (start_det) begin
                byte_cnt_reg <= 9'h000;
            end else if ((rx_byte | tx_ack) && !byte_cnt_reg[8]) begin
                byte_cnt_reg <= byte_cnt_reg + 9'h001;
            end
            rw_reg <= addr_byte ? sda_s : rw_reg;
            // Receiver ack sampled on the ninth rise
            tx_nack_reg <= tx_ack ? sda_s : tx_nack_reg;
            if (addr_byte | rx_byte) begin
                use_auto_reg <= ~bc_set;
                auto_val_reg <= rx_byte & ~beyond;
            end
            ack_sent_reg <= ack_slot ? ack_now : ack_sent_reg;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addressed_reg <= 1'b0;
            addr_nack_reg <= 1'b0;
        end else if (start_det | stop_det) begin
            addressed_reg <= 1'b0;
            addr_nack_reg <= 1'b0;
        end else if (addr_slot) begin
            addressed_reg <= ack_now;
            addr_nack_reg <= ~ack_now;
        end
    end

    // Status bits; a hardware set always wins over a same-cycle clear
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_err_reg <= 1'b0;
            stop_reg <= 1'b0;
            addr_reg <= 1'b0;
            lrb_reg <= 1'b0;
            bc_reg <= 1'b0;
        end else begin
            bus_err_reg <= ((start_det | stop_det) & ~edge_ok) | (bus_err_reg & keep_err);
            stop_reg <= (stop_det & addressed_reg) | (stop_reg & keep_stop);
            addr_reg <= addr_take | (addr_reg & keep_addr &
                        ~(stop_det & hw_match_enable & addr_nack_reg));
            lrb_reg <= ~start_det & (tx_ack ? sda_s : (lrb_reg & keep_lrb));
            // Byte complete clears lose to a new byte
            bc_reg <= bc_set | (bc_reg & keep_bc & ~start_det &
                      ~(wr_scr & hw_match_enable & stop_reg & ~reg_wdata_i[isbh_pkg::B_ACK]));
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ack_ctl_reg <= 1'b0;
            xmit_reg <= 1'b0;
        end else begin
            ack_ctl_reg <= ack_eff;
            xmit_reg <= ~start_det & xmit_eff;
        end
    end

    // Stretch from a pending falling edge to the next control write
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_reg <= 1'b0;
            stall_reg <= 1'b0;
        end else begin
            pend_reg <= bc_set | (pend_reg & ~wr_scr & ~start_det & ~stop_det);
            stall_reg <= ~wr_scr & ~start_det & ~stop_det & (stall_reg | (scl_fall & pend_reg));
        end
    end

    // SCL release and the new SDA level reach the pins in the same cycle
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
        end else begin
            rdata_reg <= reg_rd_i ? rd_mux : 8'h00;
            irq_reg <= bc_reg | addr_reg | stop_reg;
            scl_oe_n_reg <= ~stall_reg;
            sda_oe_n_reg <= ~sda_drv_reg;
        end
    end

    // Open-drain pins only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n_o = scl_oe_n_reg;
    assign sda_oe_n_o = sda_oe_n_reg;
    assign reg_rdata_o = rdata_reg;
    assign irq_o = irq_reg;
endmodule : isbh_slave

/* isbh_slave_asserts.sv */
// Port-level assertions for the I2C slave byte handshake block
`timescale 1ns/1ps
module isbh_slave_asserts #(
    parameter int BUF_DEPTH = 32
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o
);
    wire logic scr_wr = reg_wr_i && reg_addr_i == isbh_pkg::ADDR_SCR;
    wire logic rd_scr = reg_rd_i && reg_addr_i == isbh_pkg::ADDR_SCR;
    wire logic rd_none = reg_rd_i && (reg_addr_i > isbh_pkg::ADDR_OWN);
    // Shifter only moves on SCL rises, so hold SCL low for readback
    wire logic wr_dat = reg_wr_i && reg_addr_i == isbh_pkg::ADDR_DATA && !scl_i;
    wire logic rd_dat = reg_rd_i && reg_addr_i == isbh_pkg::ADDR_DATA && !scl_i;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    reset_idle_a: assert property ($rose(nrst_i) |-> scl_oe_n_o && sda_oe_n_o && !irq_o)
        else $error("Outputs not idle after reset");
    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("Read data not zero outside answer cycle");
    unmapped_zero_a: assert property ($past(rd_none) |-> reg_rdata_o == 8'h00)
        else $error("Unmapped read not zero");
    status_irq_a: assert property ($past(rd_scr) |->
        irq_o == (reg_rdata_o[5] | reg_rdata_o[3] | reg_rdata_o[0]) && !reg_rdata_o[6])
        else $error("Interrupt disagrees with status flags");
    stall_hold_a: assert property (!scl_oe_n_o && !scr_wr && !$past(scr_wr) |=> !scl_oe_n_o)
        else $error("Stall released without control write");
    stall_release_a: assert property (scr_wr && !scl_oe_n_o |-> ##[1:3] scl_oe_n_o)
        else $error("Stall not released after control write");
    stall_cause_a: assert property ($fell(scl_oe_n_o) |-> irq_o)
        else $error("Stall without pending event");
    data_readback_a: assert property (wr_dat ##2 rd_dat |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("Data register readback mismatch");
    open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("Pin output level not low");
    cover property ($fell(scl_oe_n_o));
    cover property ($rose(irq_o));
    cover property ($fell(sda_oe_n_o));
endmodule : isbh_slave_asserts

bind isbh_slave isbh_slave_asserts #(.BUF_DEPTH(BUF_DEPTH)) u_asserts (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o)
);

/* isbh_i2c_master.sv */
// Behavioural I2C bus master for the slave bench
`timescale 1ns/1ps
module isbh_i2c_master (
    input wire logic scl_w_i,
    input wire logic sda_w_i,
    output logic scl_m_o,
    output logic sda_m_o
);
    initial begin
        scl_m_o = 1'b1;
        sda_m_o = 1'b1;
    end
    // Honour stretching, bounded so a stuck slave cannot hang us
    task automatic rise();
        int n;
        n = 0;
        scl_m_o = 1'b1;
        while (scl_w_i !== 1'b1 && n < 4000) begin
            #10;
            n++;
        end
    endtask : rise
    // Long low phase gives the slave time to set up SDA
    task automatic bit_x(input logic v, output logic s);
        #10 sda_m_o = v;
        #130 rise();
        #50 s = sda_w_i;
        #10 scl_m_o = 1'b0;
    endtask : bit_x
    task automatic send_byte(input logic [7:0] b, output logic [7:0] q);
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], q[i]);
        end
    endtask : send_byte
    task automatic start_c();
        sda_m_o = 1'b1;
        #40 rise();
        #60 sda_m_o = 1'b0;
        #60 scl_m_o = 1'b0;
    endtask : start_c
    task automatic stop_c();
        #10 sda_m_o = 1'b0;
        #40 rise();
        #60 sda_m_o = 1'b1;
        #100;
    endtask : stop_c
endmodule : isbh_i2c_master

/* i2c_slave_byte_handshake_test.sv */
// Self-checking bench for the I2C slave byte handshake block
`timescale 1ns/1ps
module i2c_slave_byte_handshake_test;
    localparam logic [7:0] SCR = isbh_pkg::ADDR_SCR;
    localparam logic [7:0] DAT = isbh_pkg::ADDR_DATA;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [7:0] q;
    logic irq_o, scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, scl_m, sda_m, a;
    int failures = 0;
    int num_checks = 0;
    // Open-drain wires with pull-ups
    wire logic scl_w = scl_m & (scl_oe_n_o | scl_o);
    wire logic sda_w = sda_m & (sda_oe_n_o | sda_o);
    always #12.5 clk_sys_i = ~clk_sys_i;
    isbh_slave #(.BUF_DEPTH(32)) dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .scl_i(scl_w), .scl_o(scl_o),
        .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o)
    );
    isbh_i2c_master m (.scl_w_i(scl_w), .sda_w_i(sda_w), .scl_m_o(scl_m), .sda_m_o(sda_m));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input logic [7:0] mk = 8'hff);
        @(posedge clk_sys_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 check(reg_rdata_o & mk, exp);
    endtask : rd
    task automatic ack_slot(input logic v, input logic [7:0] exp);
        m.bit_x(v, a);
        check({7'h00, a}, exp);
    endtask : ack_slot
    task automatic byte_in(input logic [7:0] b);
        m.send_byte(b, q);
        repeat (8) @(posedge clk_sys_i);
    endtask : byte_in
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rd(SCR, 8'h00);
        rd(8'he0, 8'h00);
        wr(DAT, 8'h5a);
        rd(DAT, 8'h5a);
        // Master write: address, one data byte, NACK, stop
        m.start_c();
        byte_in(8'ha0);
        rd(SCR, 8'h09);
        check({7'h00, irq_o}, 8'h01);
        check({7'h00, scl_oe_n_o}, 8'h00);
        rd(DAT, 8'ha0);
        wr(SCR, 8'h10);
        ack_slot(1'b1, 8'h00);
        byte_in(8'hc3);
        rd(SCR, 8'h11);
        rd(DAT, 8'hc3);
        wr(SCR, 8'h00);
        ack_slot(1'b1, 8'h01);
        m.stop_c();
        rd(SCR, 8'h20);
        wr(SCR, 8'ha3);
        rd(SCR, 8'h20);
        wr(SCR, 8'h00);
        rd(SCR, 8'h00);
        // Master read, peer NACK, then restart
        m.start_c();
        byte_in(8'ha1);
        rd(SCR, 8'h09);
        wr(DAT, 8'h96);
        rd(DAT, 8'h96);
        wr(SCR, 8'h14);
        ack_slot(1'b1, 8'h00);
        m.send_byte(8'hff, q);
        check(q, 8'h96);
        ack_slot(1'b1, 8'h01);
        repeat (8) @(posedge clk_sys_i);
        check({7'h00, scl_oe_n_o}, 8'h00);
        rd(SCR, 8'h17);
        wr(SCR, 8'h07);
        repeat (4) @(posedge clk_sys_i);
        check({7'h00, sda_oe_n_o}, 8'h01);
        m.start_c();
        repeat (8) @(posedge clk_sys_i);
        rd(SCR, 8'h00, 8'h07);
        m.stop_c();
        wr(SCR, 8'h00);
        // Misplaced stop two bits into an address
        m.start_c();
        m.bit_x(1'b1, a);
        m.bit_x(1'b0, a);
        m.stop_c();
        repeat (8) @(posedge clk_sys_i);
        rd(SCR, 8'h80, 8'hbf);
        wr(SCR, 8'h80);
        rd(SCR, 8'h80, 8'h80);
        wr(SCR, 8'h00);
        rd(SCR, 8'h00, 8'h80);
        // Hardware matching: foreign address, then own address refused
        wr(isbh_pkg::ADDR_CFG, 8'h01);
        wr(isbh_pkg::ADDR_OWN, 8'h2a);
        m.start_c();
        m.send_byte(8'ha0, q);
        ack_slot(1'b1, 8'h01);
        m.stop_c();
        rd(SCR, 8'h00);
        m.start_c();
        byte_in(8'h54);
        rd(SCR, 8'h09);
        wr(SCR, 8'h00);
        ack_slot(1'b1, 8'h01);
        byte_in(8'h11);
        rd(SCR, 8'h00);
        m.stop_c();
        rd(SCR, 8'h00);
        report_and_stop();
    end
endmodule : i2c_slave_byte_handshake_test
